// >>> hw/ppc_pkg.sv
// Package: register map, field positions and types for pack protection
package ppc_pkg;

  // Register offsets
  localparam logic [7:0] PPC_ADDR_DISCH_CFG  = 8'h05;
  localparam logic [7:0] PPC_ADDR_CHARGE_CFG = 8'h06;
  localparam logic [7:0] PPC_ADDR_FEATURE    = 8'h07;
  localparam logic [7:0] PPC_ADDR_WR_ENABLE  = 8'h08;
  localparam logic [7:0] PPC_ADDR_CONTROL    = 8'h09;
  localparam logic [7:0] PPC_ADDR_STATUS     = 8'h0a;

  // Write-enable register fields
  localparam int PPC_WE_FEATURE_BIT = 7;
  localparam int PPC_WE_CHARGE_BIT  = 6;
  localparam int PPC_WE_DISCH_BIT   = 5;
  localparam int PPC_WE_UFLAG_HI    = 4;
  localparam int PPC_WE_UFLAG_LO    = 3;
  localparam logic [7:0] PPC_WE_RW_MASK = 8'hf8;

  // Feature register fields
  localparam int PPC_FEAT_WAKE_POL  = 0;

  // Control register fields
  localparam int PPC_CTL_DSW        = 0;
  localparam int PPC_CTL_CSW        = 1;
  localparam int PPC_CTL_REM_WAKE   = 2;
  localparam int PPC_CTL_LOAD_MON   = 3;
  localparam int PPC_CTL_DIS_DOC    = 4;
  localparam int PPC_CTL_DIS_SC     = 5;
  localparam int PPC_CTL_DIS_COC    = 6;
  localparam int PPC_CTL_SLEEP      = 7;

  // Status register fields
  localparam int PPC_ST_DOC         = 0;
  localparam int PPC_ST_SC          = 1;
  localparam int PPC_ST_COC         = 2;
  localparam int PPC_ST_LOAD_FAIL   = 3;
  localparam int PPC_ST_AWAKE       = 4;

  // Reset values
  localparam logic [7:0] PPC_RST_BYTE = 8'h00;

  // Fault event bundle from the analog comparators and delay timers
  typedef struct packed {
    logic discharge_overcurrent_flag;
    logic sc;
    logic charge_overcurrent_flag;
  } ppc_fault_t;

  // Power state, one-hot
  typedef enum logic [1:0] {
    PPC_ST_SLEEP_S = 2'b01,
    PPC_ST_WAKE_S  = 2'b10
  } ppc_pwr_t;

endpackage : ppc_pkg

// >>> hw/ppc_core.sv
// Control core of the pack protection device
`timescale 1ns/1ps
module ppc_core
(
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            srst_i,
  // Register port from the serial link decoder
  input  wire logic            reg_wr_i,
  input  wire logic [7:0]      reg_addr_i,
  input  wire logic [7:0]      reg_wdata_i,
  output logic      [7:0]      reg_rdata_o,
  // Supply monitors, high while above the power-on threshold
  input  wire logic            por_ok_i,
  // Wake pin level
  input  wire logic            wake_pin_i,
  // Qualified fault events from the comparator timers
  input  wire ppc_pkg::ppc_fault_t fault_i,
  // Load monitor comparator
  input  wire logic            load_fail_i,
  // Power and link outputs
  output logic                 regulated_supply_out_o,
  output logic                 remote_wake_o,
  output logic                 remote_wake_oe_o,
  output logic                 load_monitor_enable_o,
  output logic                 temp_supply_out_o,
  // Switch gate drives
  output logic                 discharge_switch_drive_o,
  output logic                 charge_switch_drive_o,
  output logic                 charge_switch_drive_oe_o
);

  import ppc_pkg::*;

  // Register storage
  logic [7:0] disch_cfg;    // Discharge thresholds
  logic [7:0] charge_cfg;   // Charge thresholds
  logic [7:0] feature_cfg;  // Feature settings
  logic [7:0] wr_enable;    // Write gates and user flags
  logic [7:0] control;      // Switch and wake control
  logic [2:0] fault_flags;  // Sticky fault flags
  logic       wake_pin_q;   // Previous wake pin level
  ppc_pwr_t   pwr_state;    // Sleep or awake

  // Internal decode
  logic       any_fault;    // A fault qualified this cycle
  logic       auto_off;     // A fault that is allowed to act
  logic       wake_edge;    // Wake edge of chosen polarity

  // Decode match helper, used for every register
  function automatic logic ppc_hit(input logic [7:0] a,
                                   input logic [7:0] b);
    ppc_hit = reg_wr_i && (a == b);
  endfunction : ppc_hit

  // Fault qualification against per-fault disable bits
  always_comb begin
    any_fault = fault_i.discharge_overcurrent_flag | fault_i.sc | fault_i.charge_overcurrent_flag;
    auto_off  = (fault_i.discharge_overcurrent_flag & ~control[PPC_CTL_DIS_DOC])
              | (fault_i.sc  & ~control[PPC_CTL_DIS_SC])
              | (fault_i.charge_overcurrent_flag & ~control[PPC_CTL_DIS_COC]);
  end

  // Wake edge select; polarity 0 wakes on a falling pin
  always_comb begin
    if (feature_cfg[PPC_FEAT_WAKE_POL]) begin
      wake_edge = wake_pin_i & ~wake_pin_q;
    end else begin
      wake_edge = ~wake_pin_i & wake_pin_q;
    end
  end

  // Previous wake pin sample for edge detection
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wake_pin_q <= 1'b0;
    end else begin
      wake_pin_q <= wake_pin_i;
    end
  end

  // Protected configuration registers; blocked writes vanish silently
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      disch_cfg   <= PPC_RST_BYTE;
      charge_cfg  <= PPC_RST_BYTE;
      feature_cfg <= PPC_RST_BYTE;
    end else begin
      if (ppc_hit(reg_addr_i, PPC_ADDR_FEATURE) &&
          wr_enable[PPC_WE_FEATURE_BIT]) begin
        feature_cfg <= reg_wdata_i;
      end
      if (ppc_hit(reg_addr_i, PPC_ADDR_CHARGE_CFG) &&
          wr_enable[PPC_WE_CHARGE_BIT]) begin
        charge_cfg <= reg_wdata_i;
      end
      if (ppc_hit(reg_addr_i, PPC_ADDR_DISCH_CFG) &&
          wr_enable[PPC_WE_DISCH_BIT]) begin
        disch_cfg <= reg_wdata_i;
      end
    end
  end

  // Write-enable register; reserved bits never store
  // User flags live in the always-on domain, so only reset or a write to this register clears them
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_enable <= PPC_RST_BYTE;
    end else if (ppc_hit(reg_addr_i, PPC_ADDR_WR_ENABLE)) begin
      wr_enable <= reg_wdata_i & PPC_WE_RW_MASK;
    end
  end

  // Power sequencing: wake needs all supplies good
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pwr_state <= PPC_ST_SLEEP_S;
    end else begin
      case (pwr_state)
        PPC_ST_SLEEP_S: begin
          // Power-up needs good supplies; after a host sleep the pin
          // edge of the chosen polarity is needed as well
          if (por_ok_i && (!control[PPC_CTL_SLEEP] || wake_edge)) begin
            pwr_state <= PPC_ST_WAKE_S;
          end
        end
        PPC_ST_WAKE_S: begin
          // Undervoltage or host sleep command ends the wake period
          if (!por_ok_i || control[PPC_CTL_SLEEP]) begin
            pwr_state <= PPC_ST_SLEEP_S;
          end
        end
        default: begin
          pwr_state <= PPC_ST_SLEEP_S;
        end
      endcase
    end
  end

  // Control register; fault shutdown beats a host write the same cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      control <= PPC_RST_BYTE;
    end else begin
      if (ppc_hit(reg_addr_i, PPC_ADDR_CONTROL)) begin
        control <= reg_wdata_i;
      end
      if (!por_ok_i) begin
        // Undervoltage turns the next wake into a plain power-up
        control[PPC_CTL_SLEEP] <= 1'b0;
      end
      if (pwr_state == PPC_ST_SLEEP_S && wake_edge) begin
        // Sleep request stands while asleep until the pin edge, undervoltage or a host write ends it
        control[PPC_CTL_SLEEP] <= 1'b0;
      end
      if (auto_off) begin
        control[PPC_CTL_DSW] <= 1'b0;
        control[PPC_CTL_CSW] <= 1'b0;
      end
    end
  end

  // Sticky fault flags; set wins over a host clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fault_flags <= 3'h0;
    end else begin
      if (ppc_hit(reg_addr_i, PPC_ADDR_STATUS)) begin
        // Write one to clear
        fault_flags <= fault_flags & ~reg_wdata_i[2:0];
      end
      if (fault_i.discharge_overcurrent_flag) begin
        fault_flags[PPC_ST_DOC] <= 1'b1;
      end
      if (fault_i.sc) begin
        fault_flags[PPC_ST_SC] <= 1'b1;
      end
      if (fault_i.charge_overcurrent_flag) begin
        fault_flags[PPC_ST_COC] <= 1'b1;
      end
    end
  end

  // Output stage: gates follow control bits, registered
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      discharge_switch_drive_o <= 1'b0;
      charge_switch_drive_o    <= 1'b0;
      charge_switch_drive_oe_o <= 1'b0;
      regulated_supply_out_o   <= 1'b0;
      remote_wake_o            <= 1'b0;
      remote_wake_oe_o         <= 1'b0;
      load_monitor_enable_o    <= 1'b0;
      temp_supply_out_o        <= 1'b0;
    end else begin
      // Discharge gate actively pulled low on shutdown
      discharge_switch_drive_o <= control[PPC_CTL_DSW] & ~auto_off;
      // Charge gate released so the external resistor pulls it low
      charge_switch_drive_o    <= 1'b1;
      charge_switch_drive_oe_o <= control[PPC_CTL_CSW] & ~auto_off;
      regulated_supply_out_o   <= (pwr_state == PPC_ST_WAKE_S);
      // Open-drain low pull wakes the companion
      remote_wake_o            <= 1'b0;
      remote_wake_oe_o         <= control[PPC_CTL_REM_WAKE];
      load_monitor_enable_o    <= control[PPC_CTL_LOAD_MON];
      temp_supply_out_o        <= (|fault_flags) | any_fault;
    end
  end

  // Read data register; the address is sampled every clock, so the
  // answer stands one edge after the address settles
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= PPC_RST_BYTE;
    end else if (reg_addr_i == PPC_ADDR_DISCH_CFG) begin
      reg_rdata_o <= disch_cfg;
    end else if (reg_addr_i == PPC_ADDR_CHARGE_CFG) begin
      reg_rdata_o <= charge_cfg;
    end else if (reg_addr_i == PPC_ADDR_FEATURE) begin
      reg_rdata_o <= feature_cfg;
    end else if (reg_addr_i == PPC_ADDR_WR_ENABLE) begin
      reg_rdata_o <= wr_enable;
    end else if (reg_addr_i == PPC_ADDR_CONTROL) begin
      reg_rdata_o <= control;
    end else if (reg_addr_i == PPC_ADDR_STATUS) begin
      reg_rdata_o <= {3'h0, (pwr_state == PPC_ST_WAKE_S), load_fail_i,
                      fault_flags};
    end else begin
      reg_rdata_o <= PPC_RST_BYTE;  // Unmapped reads return zero
    end
  end

  // Blocked feature write leaves the register as it was
  a_feat_block: assert property (@(posedge clk_i) disable iff (srst_i)
    (reg_wr_i && reg_addr_i == PPC_ADDR_FEATURE &&
     !wr_enable[PPC_WE_FEATURE_BIT]) |=> $stable(feature_cfg))
    else $error("feature register changed while locked");

  a_chg_block: assert property (@(posedge clk_i) disable iff (srst_i)
    (reg_wr_i && reg_addr_i == PPC_ADDR_CHARGE_CFG &&
     !wr_enable[PPC_WE_CHARGE_BIT]) |=> $stable(charge_cfg))
    else $error("charge register changed while locked");

  a_dis_block: assert property (@(posedge clk_i) disable iff (srst_i)
    (reg_wr_i && reg_addr_i == PPC_ADDR_DISCH_CFG &&
     !wr_enable[PPC_WE_DISCH_BIT]) |=> $stable(disch_cfg))
    else $error("discharge register changed while locked");

  a_reserved_zero: assert property (@(posedge clk_i)
    disable iff (srst_i) wr_enable[2:0] == 3'h0)
    else $error("reserved enable bits set");

  a_wake_good: assert property (@(posedge clk_i)
    disable iff (srst_i) $rose(regulated_supply_out_o) |-> $past(por_ok_i, 2))
    else $error("supply output rose without good supplies");

  a_fault_off: assert property (@(posedge clk_i) disable iff (srst_i)
    auto_off |=> !discharge_switch_drive_o && !charge_switch_drive_oe_o
                 && !control[PPC_CTL_DSW] && !control[PPC_CTL_CSW])
    else $error("switches not off after fault");

  a_flag_set: assert property (@(posedge clk_i) disable iff (srst_i)
    fault_i.sc |=> fault_flags[PPC_ST_SC])
    else $error("short flag not set");

  a_temp_wake: assert property (@(posedge clk_i) disable iff (srst_i)
    (fault_i.discharge_overcurrent_flag || fault_i.sc || fault_i.charge_overcurrent_flag) |=> temp_supply_out_o)
    else $error("temperature supply not driven on fault");

  a_remote_low: assert property (@(posedge clk_i) disable iff (srst_i)
    control[PPC_CTL_REM_WAKE] |=> remote_wake_oe_o && !remote_wake_o)
    else $error("remote wake not pulled low");

  // A commanded sleep takes effect at the next edge
  a_sleep_entry: assert property (@(posedge clk_i)
    disable iff (srst_i)
    (pwr_state == PPC_ST_WAKE_S && control[PPC_CTL_SLEEP])
    |=> pwr_state == PPC_ST_SLEEP_S)
    else $error("sleep command did not end the wake period");

  // Supply loss drops the regulator output two edges later
  a_supply_drop: assert property (@(posedge clk_i)
    disable iff (srst_i) !por_ok_i |=> ##1 !regulated_supply_out_o)
    else $error("supply output stayed on below threshold");

  // While the host sleep request stands only a moving wake pin may wake the part
  a_pin_hold: assert property (@(posedge clk_i)
    disable iff (srst_i)
    (pwr_state == PPC_ST_SLEEP_S && control[PPC_CTL_SLEEP] &&
     $stable(wake_pin_i)) |=> pwr_state == PPC_ST_SLEEP_S)
    else $error("woke from sleep without a pin edge");

  // User flags and gates only change on a write to their register
  a_flags_kept: assert property (@(posedge clk_i)
    disable iff (srst_i)
    !(reg_wr_i && reg_addr_i == PPC_ADDR_WR_ENABLE) |=> $stable(wr_enable))
    else $error("write-enable register changed without a write");

  // Each fault kind latches its own flag
  a_doc_flag: assert property (@(posedge clk_i)
    disable iff (srst_i) fault_i.discharge_overcurrent_flag |=> fault_flags[PPC_ST_DOC])
    else $error("discharge overcurrent flag not set");

  a_coc_flag: assert property (@(posedge clk_i)
    disable iff (srst_i) fault_i.charge_overcurrent_flag |=> fault_flags[PPC_ST_COC])
    else $error("charge overcurrent flag not set");

  // Disabled faults leave the switch bits where the host put them
  a_auto_keep: assert property (@(posedge clk_i)
    disable iff (srst_i)
    (!reg_wr_i && (!fault_i.discharge_overcurrent_flag || control[PPC_CTL_DIS_DOC]) &&
     (!fault_i.sc || control[PPC_CTL_DIS_SC]) &&
     (!fault_i.charge_overcurrent_flag || control[PPC_CTL_DIS_COC]))
    |=> $stable(control[1:0]))
    else $error("switch bits moved by a disabled fault");

  // A host write while awake lands in full when no fault acts
  a_ctl_write: assert property (@(posedge clk_i)
    disable iff (srst_i)
    (reg_wr_i && reg_addr_i == PPC_ADDR_CONTROL && por_ok_i &&
     pwr_state == PPC_ST_WAKE_S &&
     !(fault_i.discharge_overcurrent_flag || fault_i.sc || fault_i.charge_overcurrent_flag))
    |=> control == $past(reg_wdata_i))
    else $error("control write did not land");

endmodule : ppc_core

// >>> sim/ppc_host_model.sv
// Host microcontroller model with the pull resistors on the far side
`timescale 1ns/1ps
module ppc_host_model
  import ppc_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // Register port towards the core
  output logic            reg_wr_o,
  output logic [7:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i,
  // Pins seen from the board
  input  wire logic       charge_drive_i,
  input  wire logic       charge_oe_i,
  input  wire logic       remote_wake_i,
  input  wire logic       remote_oe_i,
  output logic            charge_gate_o,
  output logic            companion_wake_o
);
  // Released gate falls to ground through its resistor
  assign charge_gate_o = charge_oe_i ? charge_drive_i : 1'b0;
  // Companion wake pin idles high, active low at default polarity
  assign companion_wake_o = remote_oe_i ? remote_wake_i : 1'b1;

  initial begin
    reg_wr_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // One-cycle write strobe, held across one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = 1'b1;
    @(posedge clk_i);
    #1;
    reg_wr_o    = 1'b0;
    reg_wdata_o = ~d;
  endtask : wr

  // Read data is registered; it stands one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    reg_addr_o = a;
    @(posedge clk_i);
    #1;
    d = reg_rdata_i;
  endtask : rd
endmodule : ppc_host_model

// >>> sim/tb_top.sv
// Self-checking bench for the pack protection core
`timescale 1ns/1ps
module tb_top;
  import ppc_pkg::*;
  logic       clk_i, srst_i, por_ok_i, wake_pin_i, load_fail_i;
  ppc_fault_t fault_i;
  logic       reg_wr, ld_en, temp_o, dsw, csw, csw_oe, rw, rw_oe, sup;
  logic [7:0] reg_addr, reg_wdata, rdata, got;
  logic       cgate, cwake;
  int         error_cnt, n_tests;
  // Row: write address and data, then expected read-back
  typedef struct { logic [7:0] a; logic [7:0] d; logic [7:0] e; } row_t;
  row_t rows[10] = '{
    '{8'h07, 8'h01, 8'h00}, '{8'h06, 8'h55, 8'h00}, '{8'h05, 8'haa, 8'h00},
    '{8'h08, 8'hff, 8'hf8}, '{8'h07, 8'h01, 8'h01}, '{8'h06, 8'h55, 8'h55},
    '{8'h05, 8'haa, 8'haa}, '{8'h08, 8'h18, 8'h18}, '{8'h05, 8'h00, 8'haa},
    '{8'h0f, 8'h5a, 8'h00}};

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  ppc_core ppc_core_i (.clk_i(clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(rdata),
    .por_ok_i(por_ok_i), .wake_pin_i(wake_pin_i), .fault_i(fault_i),
    .load_fail_i(load_fail_i), .regulated_supply_out_o(sup),
    .remote_wake_o(rw), .remote_wake_oe_o(rw_oe),
    .load_monitor_enable_o(ld_en), .temp_supply_out_o(temp_o),
    .discharge_switch_drive_o(dsw), .charge_switch_drive_o(csw),
    .charge_switch_drive_oe_o(csw_oe));

  ppc_host_model ppc_host_model_i (.clk_i(clk_i), .reg_wr_o(reg_wr),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_rdata_i(rdata),
    .charge_drive_i(csw), .charge_oe_i(csw_oe), .remote_wake_i(rw),
    .remote_oe_i(rw_oe), .charge_gate_o(cgate), .companion_wake_o(cwake));

  // Compare and count
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // Let registered pins follow a register change
  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask : settle

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  // Watchdog sized well above the expected run
  initial begin
    #(3000 * 50);
    error_cnt++;
    wrap_up();
  end

  initial begin
    srst_i = 1'b1;
    por_ok_i = 1'b0;
    wake_pin_i = 1'b1;
    load_fail_i = 1'b0;
    fault_i = '0;
    error_cnt = 0;
    n_tests = 0;
    repeat (12) @(posedge clk_i);
    #1;
    chk({dsw, csw_oe, temp_o, sup}, 8'h00);
    srst_i = 1'b0;
    // Supplies below threshold keep the part asleep
    settle();
    chk({7'h00, sup}, 8'h00);
    por_ok_i = 1'b1;
    settle();
    chk({7'h00, sup}, 8'h01);
    // Register table walk, blocked writes first
    foreach (rows[i]) begin
      ppc_host_model_i.wr(rows[i].a, rows[i].d);
      ppc_host_model_i.rd(rows[i].a, got);
      chk(got, rows[i].e);
    end
    // Load-fail bit is visible to the host before any switch-on
    load_fail_i = 1'b1;
    ppc_host_model_i.rd(PPC_ADDR_STATUS, got);
    chk(got & 8'h08, 8'h08);
    load_fail_i = 1'b0;
    // Each fault kind shuts both switches and flags the host
    for (int k = 0; k < 3; k++) begin
      ppc_host_model_i.rd(PPC_ADDR_STATUS, got);
      chk(got & 8'h08, 8'h00);
      ppc_host_model_i.wr(PPC_ADDR_CONTROL, 8'h03);
      settle();
      chk({6'h00, dsw, cgate}, 8'h03);
      @(posedge clk_i);
      #1;
      fault_i = ppc_fault_t'(3'b100 >> k);
      @(posedge clk_i);
      #1;
      fault_i = '0;
      settle();
      chk({5'h00, dsw, cgate, temp_o}, 8'h01);
      ppc_host_model_i.rd(PPC_ADDR_CONTROL, got);
      chk(got, 8'h00);
      ppc_host_model_i.rd(PPC_ADDR_STATUS, got);
      chk(got & 8'h07, 8'(1 << k));
      ppc_host_model_i.wr(PPC_ADDR_STATUS, 8'(1 << k));
      settle();
      chk({7'h00, temp_o}, 8'h00);
    end
    // Automatic response off: flags only, switches stay on
    ppc_host_model_i.wr(PPC_ADDR_CONTROL, 8'h7b);
    @(posedge clk_i);
    #1;
    fault_i = ppc_fault_t'(3'b111);
    @(posedge clk_i);
    #1;
    fault_i = '0;
    settle();
    chk({5'h00, dsw, cgate, ld_en}, 8'h07);
    ppc_host_model_i.rd(PPC_ADDR_STATUS, got);
    chk(got & 8'h07, 8'h07);
    ppc_host_model_i.rd(PPC_ADDR_CONTROL, got);
    chk(got, 8'h7b);
    // Remote wake pulls the companion pin low
    ppc_host_model_i.wr(PPC_ADDR_CONTROL, 8'h04);
    settle();
    chk({7'h00, cwake}, 8'h00);
    ppc_host_model_i.wr(PPC_ADDR_CONTROL, 8'h00);
    settle();
    chk({7'h00, cwake}, 8'h01);
    // Host sleep holds until a pin edge of the chosen polarity
    ppc_host_model_i.wr(PPC_ADDR_CONTROL, 8'h80);
    settle();
    chk({7'h00, sup}, 8'h00);
    wake_pin_i = 1'b0;
    settle();
    chk({7'h00, sup}, 8'h00);
    wake_pin_i = 1'b1;
    settle();
    chk({7'h00, sup}, 8'h01);
    // Back to falling-edge wake; user flags survive the sleep
    ppc_host_model_i.wr(PPC_ADDR_WR_ENABLE, 8'h98);
    ppc_host_model_i.wr(PPC_ADDR_FEATURE, 8'h00);
    ppc_host_model_i.wr(PPC_ADDR_CONTROL, 8'h80);
    settle();
    chk({7'h00, sup}, 8'h00);
    wake_pin_i = 1'b0;
    settle();
    chk({7'h00, sup}, 8'h01);
    ppc_host_model_i.rd(PPC_ADDR_WR_ENABLE, got);
    chk(got, 8'h98);
    // Supply collapse ends the awake state
    por_ok_i = 1'b0;
    settle();
    chk({7'h00, sup}, 8'h00);
    wrap_up();
  end
endmodule : tb_top
